// *** include/irqc_regs.svh ***
// offsets, field positions, reset values and timing counts of the interrupt block
// Operation
// - threshold_select in bits 2..0 picks one of eight supply thresholds.
// - read-only low_supply_flag in bit 5 is high while supply is low.
// - detector_enable in bit 4 switches the detector on or off.
// - in sleep the detector is off whatever its enable says.
// - bandgap runs for detector, low-voltage reset or bandgap_enable bit 3.
// - low_supply_request sets only after a fixed delay past the flag rise.
// - a set low_supply_request wakes from idle; preset it to avoid that.
// - the low-supply flag may toggle repeatedly near threshold; tolerate it.
// - edge_select: 00 off, 01 rising, 10 falling, 11 both edges.
// - primary register 0 holds global, pin, mf0, serial enables and flags.
// - primary register 1 holds time base and mf1/mf2 enables and flags.
// - primary register 2 holds low-supply, eeprom, converter enables, flags.
// - touch sub-register holds overflow and threshold enables and flags.
// - compact timer sub-register holds period and match-a enables, flags.
// - standard timer sub-register holds period and match-a flags, enables.
// - unimplemented bits read zero and ignore writes.
// - each sub-register feeds one multi-function primary request.
// - a flag interrupts only with its enable and the global enable set.
// - servicing clears the global enable and the serviced primary flag.
// - any newly set flag wakes from sleep or idle; a preset one does not. Code watches only the ten primary flags, not sub-register flags.
`ifndef IRQC_REGS_SVH
`define IRQC_REGS_SVH

`define IRQC_OFS_LVCTL 8'h00
`define IRQC_OFS_EDGE 8'h04
`define IRQC_OFS_PRI0 8'h08
`define IRQC_OFS_PRI1 8'h0c
`define IRQC_OFS_PRI2 8'h10
`define IRQC_OFS_TKSUB 8'h14
`define IRQC_OFS_CTSUB 8'h18
`define IRQC_OFS_STSUB 8'h1c

`define IRQC_RST_VAL 8'h00
`define IRQC_MSK_LVCTL 8'h1f
`define IRQC_MSK_EDGE 8'h03
`define IRQC_MSK_PRI0 8'h7f
`define IRQC_MSK_PRI1 8'hff
`define IRQC_MSK_PRI2 8'h77
`define IRQC_MSK_SUB 8'h33

`define IRQC_LVD_OUT 5
`define IRQC_LVD_EN 4
`define IRQC_BG_EN 3
`define IRQC_THR_HI 2

`define IRQC_GIE 0
`define IRQC_PINE 1
`define IRQC_MF0E 2
`define IRQC_SERE 3
`define IRQC_PINF 4
`define IRQC_MF0_REQ 5
`define IRQC_SERF 6

`define IRQC_TB0E 0
`define IRQC_TB1E 1
`define IRQC_MF1E 2
`define IRQC_MF2E 3
`define IRQC_TB0_REQ 4
`define IRQC_TB1_REQ 5
`define IRQC_MF1_REQ 6
`define IRQC_MF2_REQ 7

`define IRQC_LSE 0
`define IRQC_EEE 1
`define IRQC_ADE 2
`define IRQC_LS_REQ 4
`define IRQC_EEF 5
`define IRQC_AD_REQ 6

`define IRQC_SUB0E 0
`define IRQC_SUB1E 1
`define IRQC_SUB0F 4
`define IRQC_SUB1F 5

`define IRQC_EDGE_OFF 2'h0
`define IRQC_EDGE_RISE 2'h1
`define IRQC_EDGE_FALL 2'h2
`define IRQC_EDGE_BOTH 2'h3

`define IRQC_CLK_NS 50
`define IRQC_LVD_DLY_NS 10000
`define IRQC_LVD_DLY_CYC ((`IRQC_LVD_DLY_NS + `IRQC_CLK_NS - 1) / `IRQC_CLK_NS)
`define IRQC_LVD_CNT_W 8

`endif

// *** include/irqc_pkg.sv ***
// types shared by the interrupt block and its bench
package irqc_pkg;

  typedef enum logic [3:0] {
    IRQC_SRC_PIN,
    IRQC_SRC_MF0,
    IRQC_SRC_SER,
    IRQC_SRC_TB0,
    IRQC_SRC_TB1,
    IRQC_SRC_MF1,
    IRQC_SRC_MF2,
    IRQC_SRC_LV,
    IRQC_SRC_EE,
    IRQC_SRC_AD
  } irqc_src_e;

  typedef struct packed {
    logic serial;
    logic tb0;
    logic tb1;
    logic adc;
    logic eeprom;
    logic tk_ovf;
    logic tk_thr;
    logic ct_per;
    logic ct_ma;
    logic st_per;
    logic st_ma;
  } irqc_evt_s;

  typedef struct packed {
    logic valid;
    irqc_src_e src;
  } irqc_ack_s;

  typedef enum logic {
    IRQC_BUS_RUN,
    IRQC_BUS_RDWAIT
  } irqc_bus_e;

endpackage

// *** rtl/irqc_top.sv ***
// interrupt control with low-supply detector registers behind an ahb-lite slave
//
// The register offsets and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ns
`include "irqc_regs.svh"

module irqc_top
  import irqc_pkg::*;
(
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  input wire logic pin_in, // external interrupt pin
  input wire logic supply_below, // analog comparator, async
  input wire logic low_voltage_reset, // reset monitor enabled
  input wire logic sleep_mode, // cpu in sleep
  input wire logic idle_mode, // cpu in idle
  input wire irqc_evt_s evt, // peripheral event pulses
  input wire irqc_ack_s ack, // cpu service pulse
  output logic irq_req, // request to cpu
  output logic wake_req, // wake pulse
  output logic bandgap_on, // bandgap reference enable
  output logic detector_on, // detector power
  output logic [2:0] threshold_sel, // detector threshold code
  output logic low_supply_flag // detector output
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [7:0] wr_val(input logic hit, input logic [7:0] wd,
                                        input logic [7:0] cur, input logic [7:0] msk);
    wr_val = hit ? (wd & msk) : cur;
  endfunction

  function automatic logic subs(input logic [7:0] r);
    subs = (r[`IRQC_SUB0F] & r[`IRQC_SUB0E]) | (r[`IRQC_SUB1F] & r[`IRQC_SUB1E]);
  endfunction

  localparam int LVD_CYC = `IRQC_LVD_DLY_CYC;

  // ****************************************************************
  // ahb-lite slave
  // ****************************************************************
  irqc_bus_e bus_r;
  logic [7:0] addr_r;
  logic wr_pend_r;
  logic rd_pend_r;
  logic addr_ph;
  logic [7:0] wd;
  logic [7:0] rd_mux;

  logic [7:0] lv_ctl_r;
  logic [7:0] edge_cfg_r;
  logic [7:0] c0_r;
  logic [7:0] c1_r;
  logic [7:0] c2_r;
  logic [7:0] m0_r;
  logic [7:0] m1_r;
  logic [7:0] m2_r;

  assign addr_ph = hsel & hready & htrans[1];
  assign wd = hwdata[7:0];

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      bus_r <= IRQC_BUS_RUN;
      addr_r <= 8'h00;
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hresp <= 1'b0;
      wr_pend_r <= addr_ph & hwrite;
      rd_pend_r <= 1'b0;
      if (addr_ph)
        addr_r <= haddr[7:0];
      case (bus_r)
        IRQC_BUS_RUN:
          if (addr_ph && !hwrite)
          begin
            bus_r <= IRQC_BUS_RDWAIT;
            hreadyout <= 1'b0;
            rd_pend_r <= 1'b1;
          end
        IRQC_BUS_RDWAIT:
        begin
          bus_r <= IRQC_BUS_RUN;
          hreadyout <= 1'b1;
        end
        default:
        begin
          bus_r <= IRQC_BUS_RUN;
          hreadyout <= 1'b1;
        end
      endcase
    end

  always_comb
  begin
    case (addr_r)
      `IRQC_OFS_LVCTL: rd_mux = {2'b00, low_supply_flag, lv_ctl_r[4:0]};
      `IRQC_OFS_EDGE: rd_mux = edge_cfg_r;
      `IRQC_OFS_PRI0: rd_mux = c0_r;
      `IRQC_OFS_PRI1: rd_mux = c1_r;
      `IRQC_OFS_PRI2: rd_mux = c2_r;
      `IRQC_OFS_TKSUB: rd_mux = m0_r;
      `IRQC_OFS_CTSUB: rd_mux = m1_r;
      `IRQC_OFS_STSUB: rd_mux = m2_r;
      default: rd_mux = 8'h00;
    endcase
  end

  // read data is fetched in the wait cycle so a preceding write is seen
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (rd_pend_r)
      hrdata <= {24'h00_0000, rd_mux};

  function automatic logic hit(input logic [7:0] ofs);
    hit = wr_pend_r && (addr_r == ofs);
  endfunction

  // ****************************************************************
  // low-supply detector
  // ****************************************************************
  logic sup_s1;
  logic sup_s2;
  logic det_act;
  logic [`IRQC_LVD_CNT_W-1:0] lvd_cnt_r;
  logic ls_req_set;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      lv_ctl_r <= `IRQC_RST_VAL;
    else
      lv_ctl_r <= wr_val(hit(`IRQC_OFS_LVCTL), wd, lv_ctl_r, `IRQC_MSK_LVCTL);

  assign det_act = lv_ctl_r[`IRQC_LVD_EN] & ~sleep_mode;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      sup_s1 <= 1'b0;
      sup_s2 <= 1'b0;
    end
    else
    begin
      sup_s1 <= supply_below;
      sup_s2 <= sup_s1;
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      low_supply_flag <= 1'b0;
      detector_on <= 1'b0;
      bandgap_on <= 1'b0;
      threshold_sel <= 3'h0;
    end
    else
    begin
      low_supply_flag <= det_act & sup_s2;
      detector_on <= det_act;
      bandgap_on <= det_act | low_voltage_reset | lv_ctl_r[`IRQC_BG_EN];
      threshold_sel <= lv_ctl_r[`IRQC_THR_HI:0];
    end

  // delay restarts on every fall of the flag, so chatter near threshold is harmless
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      lvd_cnt_r <= '0;
    else if (!low_supply_flag)
      lvd_cnt_r <= '0;
    else if (lvd_cnt_r != LVD_CYC[`IRQC_LVD_CNT_W-1:0])
      lvd_cnt_r <= lvd_cnt_r + 1'b1;

  assign ls_req_set = low_supply_flag &&
                   (lvd_cnt_r == LVD_CYC[`IRQC_LVD_CNT_W-1:0] - 1'b1);

  // ****************************************************************
  // external pin edge detect
  // ****************************************************************
  logic pin_s1;
  logic pin_s2;
  logic pin_s3;
  logic pin_set;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      edge_cfg_r <= `IRQC_RST_VAL;
    else
      edge_cfg_r <= wr_val(hit(`IRQC_OFS_EDGE), wd, edge_cfg_r, `IRQC_MSK_EDGE);

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
    end
    else
    begin
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end

  always_comb
  begin
    case (edge_cfg_r[1:0])
      `IRQC_EDGE_RISE: pin_set = pin_s2 & ~pin_s3;
      `IRQC_EDGE_FALL: pin_set = ~pin_s2 & pin_s3;
      `IRQC_EDGE_BOTH: pin_set = pin_s2 ^ pin_s3;
      default: pin_set = 1'b0;
    endcase
  end

  // ****************************************************************
  // sub-source registers
  // ****************************************************************
  logic [7:0] m0_nxt;
  logic [7:0] m1_nxt;
  logic [7:0] m2_nxt;

  always_comb
  begin
    m0_nxt = wr_val(hit(`IRQC_OFS_TKSUB), wd, m0_r, `IRQC_MSK_SUB);
    m1_nxt = wr_val(hit(`IRQC_OFS_CTSUB), wd, m1_r, `IRQC_MSK_SUB);
    m2_nxt = wr_val(hit(`IRQC_OFS_STSUB), wd, m2_r, `IRQC_MSK_SUB);
    m0_nxt[`IRQC_SUB0F] = m0_nxt[`IRQC_SUB0F] | evt.tk_ovf;
    m0_nxt[`IRQC_SUB1F] = m0_nxt[`IRQC_SUB1F] | evt.tk_thr;
    m1_nxt[`IRQC_SUB0F] = m1_nxt[`IRQC_SUB0F] | evt.ct_per;
    m1_nxt[`IRQC_SUB1F] = m1_nxt[`IRQC_SUB1F] | evt.ct_ma;
    m2_nxt[`IRQC_SUB0F] = m2_nxt[`IRQC_SUB0F] | evt.st_per;
    m2_nxt[`IRQC_SUB1F] = m2_nxt[`IRQC_SUB1F] | evt.st_ma;
  end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      m0_r <= `IRQC_RST_VAL;
      m1_r <= `IRQC_RST_VAL;
      m2_r <= `IRQC_RST_VAL;
    end
    else
    begin
      m0_r <= m0_nxt;
      m1_r <= m1_nxt;
      m2_r <= m2_nxt;
    end

  // ****************************************************************
  // primary registers
  // ****************************************************************
  logic [7:0] c0_nxt;
  logic [7:0] c1_nxt;
  logic [7:0] c2_nxt;

  function automatic logic svc(input irqc_src_e s);
    svc = ack.valid && (ack.src == s);
  endfunction

  // order: software write, then service clear, then hardware set wins
  always_comb
  begin
    c0_nxt = wr_val(hit(`IRQC_OFS_PRI0), wd, c0_r, `IRQC_MSK_PRI0);
    c1_nxt = wr_val(hit(`IRQC_OFS_PRI1), wd, c1_r, `IRQC_MSK_PRI1);
    c2_nxt = wr_val(hit(`IRQC_OFS_PRI2), wd, c2_r, `IRQC_MSK_PRI2);
    if (ack.valid)
      c0_nxt[`IRQC_GIE] = 1'b0;
    if (svc(IRQC_SRC_PIN))
      c0_nxt[`IRQC_PINF] = 1'b0;
    if (svc(IRQC_SRC_MF0))
      c0_nxt[`IRQC_MF0_REQ] = 1'b0;
    if (svc(IRQC_SRC_SER))
      c0_nxt[`IRQC_SERF] = 1'b0;
    if (svc(IRQC_SRC_TB0))
      c1_nxt[`IRQC_TB0_REQ] = 1'b0;
    if (svc(IRQC_SRC_TB1))
      c1_nxt[`IRQC_TB1_REQ] = 1'b0;
    if (svc(IRQC_SRC_MF1))
      c1_nxt[`IRQC_MF1_REQ] = 1'b0;
    if (svc(IRQC_SRC_MF2))
      c1_nxt[`IRQC_MF2_REQ] = 1'b0;
    if (svc(IRQC_SRC_LV))
      c2_nxt[`IRQC_LS_REQ] = 1'b0;
    if (svc(IRQC_SRC_EE))
      c2_nxt[`IRQC_EEF] = 1'b0;
    if (svc(IRQC_SRC_AD))
      c2_nxt[`IRQC_AD_REQ] = 1'b0;
    c0_nxt[`IRQC_PINF] = c0_nxt[`IRQC_PINF] | pin_set;
    c0_nxt[`IRQC_MF0_REQ] = c0_nxt[`IRQC_MF0_REQ] | subs(m0_r);
    c0_nxt[`IRQC_SERF] = c0_nxt[`IRQC_SERF] | evt.serial;
    c1_nxt[`IRQC_TB0_REQ] = c1_nxt[`IRQC_TB0_REQ] | evt.tb0;
    c1_nxt[`IRQC_TB1_REQ] = c1_nxt[`IRQC_TB1_REQ] | evt.tb1;
    c1_nxt[`IRQC_MF1_REQ] = c1_nxt[`IRQC_MF1_REQ] | subs(m1_r);
    c1_nxt[`IRQC_MF2_REQ] = c1_nxt[`IRQC_MF2_REQ] | subs(m2_r);
    c2_nxt[`IRQC_LS_REQ] = c2_nxt[`IRQC_LS_REQ] | ls_req_set;
    c2_nxt[`IRQC_EEF] = c2_nxt[`IRQC_EEF] | evt.eeprom;
    c2_nxt[`IRQC_AD_REQ] = c2_nxt[`IRQC_AD_REQ] | evt.adc;
  end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      c0_r <= `IRQC_RST_VAL;
      c1_r <= `IRQC_RST_VAL;
      c2_r <= `IRQC_RST_VAL;
    end
    else
    begin
      c0_r <= c0_nxt;
      c1_r <= c1_nxt;
      c2_r <= c2_nxt;
    end

  // ****************************************************************
  // cpu request and wake
  // ****************************************************************
  logic [9:0] pf_now;
  logic [9:0] pf_nxt;
  logic [9:0] pe_now;

  assign pf_now = {c0_r[6:4], c1_r[7:4], c2_r[6:4]};
  assign pf_nxt = {c0_nxt[6:4], c1_nxt[7:4], c2_nxt[6:4]};
  assign pe_now = {c0_r[3:1], c1_r[3:0], c2_r[2:0]};

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      irq_req <= 1'b0;
      wake_req <= 1'b0;
    end
    else
    begin
      irq_req <= c0_r[`IRQC_GIE] & |(pf_now & pe_now);
      wake_req <= (sleep_mode | idle_mode) & |(pf_nxt & ~pf_now);
    end

endmodule

// *** bench/irqc_cpu.sv ***
// cpu side model: services a raised request after a chosen latency
`timescale 1ns/1ns
module irqc_cpu
  import irqc_pkg::*;
(
  input wire logic hclk, // clock
  input wire logic irq_req, // request seen
  input wire logic en, // servicing allowed
  input wire logic [3:0] lat, // cycles before service
  input wire irqc_src_e src, // source serviced
  output irqc_ack_s ack // service pulse
);
  initial
  begin
    ack = '0;
    forever
    begin
      @(posedge hclk);
      if (en && irq_req)
      begin
        repeat (lat) @(posedge hclk);
        ack <= '{valid: 1'b1, src: src};
        @(posedge hclk);
        ack <= '0;
        repeat (3) @(posedge hclk);
      end
    end
  end
endmodule

// *** bench/irqc_chk.sv ***
// assertions on the ports of the interrupt block
`timescale 1ns/1ns
module irqc_chk
  import irqc_pkg::*;
(
  input wire logic hclk, // clock
  input wire logic hresetn, // reset
  input wire logic hsel, // select
  input wire logic [1:0] htrans, // type
  input wire logic hwrite, // write
  input wire logic hready, // ready in
  input wire logic [31:0] hrdata, // read data
  input wire logic hreadyout, // ready out
  input wire logic hresp, // response
  input wire logic low_voltage_reset, // reset monitor
  input wire logic sleep_mode, // sleep
  input wire logic idle_mode, // idle
  input wire irqc_ack_s ack, // service
  input wire logic irq_req, // request
  input wire logic wake_req, // wake
  input wire logic bandgap_on, // bandgap
  input wire logic detector_on, // detector
  input wire logic low_supply_flag // low supply
);
  logic low_power;
  assign low_power = sleep_mode | idle_mode;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("slave answered with an error");
  a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite
    |=> !hreadyout ##1 (hreadyout && hrdata[31:8] == 24'h0))
    else $error("read data phase wrong");
  a_det_sleep: assert property (sleep_mode |=> !detector_on)
    else $error("detector on in sleep");
  a_bg_detector: assert property (detector_on |-> bandgap_on)
    else $error("detector on without bandgap");
  a_bg_lvr: assert property (low_voltage_reset |=> bandgap_on)
    else $error("reset monitor on without bandgap");
  a_flag_off: assert property (!detector_on [*2] |-> !low_supply_flag)
    else $error("low supply flag with detector off");
  a_ack_block: assert property (ack.valid |-> ##2 !irq_req)
    else $error("request stays after service");
  a_wake_mode: assert property (wake_req |-> $past(low_power) || $past(low_power, 2))
    else $error("wake outside sleep or idle");
endmodule
bind irqc_top irqc_chk u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata,
  .hreadyout, .hresp, .low_voltage_reset, .sleep_mode, .idle_mode, .ack, .irq_req,
  .wake_req, .bandgap_on, .detector_on, .low_supply_flag);

// *** bench/tb.sv ***
// self-checking bench for the interrupt block
`timescale 1ns/1ns
module tb
  import irqc_pkg::*;
;
  logic hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, pin_in = 1'b0, supply_below = 1'b0;
  logic low_voltage_reset = 1'b0, sleep_mode = 1'b0, idle_mode = 1'b0, rd_dp = 1'b0;
  logic cpu_en = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, threshold_sel;
  logic [3:0] lat = 4'h0;
  logic hready, hreadyout, hresp, irq_req, wake_req, bandgap_on, detector_on, low_supply_flag;
  irqc_evt_s evt = '0;
  irqc_ack_s ack;
  logic [7:0] exp_q[$];
  logic [7:0] msk[8] = '{8'h1f, 8'h03, 8'h7f, 8'hff, 8'h77, 8'h33, 8'h33, 8'h33};
  int fail_count = 0, checked = 0, wakes = 0;
  assign hready = hreadyout;
  irqc_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .pin_in, .supply_below, .low_voltage_reset, .sleep_mode,
    .idle_mode, .evt, .ack, .irq_req, .wake_req, .bandgap_on, .detector_on, .threshold_sel,
    .low_supply_flag);
  irqc_cpu cpu (.hclk, .irq_req, .en(cpu_en), .lat, .src(IRQC_SRC_TB0), .ack);
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one single ahb transfer; a read notes its expected byte
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    r = $urandom;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (!hready);
    htrans <= 2'h0;
    hwdata <= {r[31:8], d};
    if (!w)
      exp_q.push_back(d);
    rd_dp <= !w;
    do @(posedge hclk); while (!hready);
    rd_dp <= 1'b0;
  endtask
  task automatic pulse(input irqc_evt_s v);
    @(posedge hclk);
    evt <= v;
    @(posedge hclk);
    evt <= '0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask
  always @(posedge hclk)
  begin
    if (wake_req === 1'b1)
      wakes++;
    if (rd_dp && hreadyout)
      chk("read data", exp_q.pop_front(), hrdata[7:0]);
  end
  initial
  begin
    #1500000;
    fail_count++;
    end_of_test;
  end
  // ************************************************
  // scenarios
  // ************************************************
  initial
  begin
    void'($urandom(32'h12c53d38));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      xfer(1'b0, 8'(i * 4), 8'h00);
      xfer(1'b1, 8'(i * 4), 8'hff);
      xfer(1'b0, 8'(i * 4), msk[i]);
      xfer(1'b1, 8'(i * 4), 8'h00);
    end
    xfer(1'b1, 8'h08, 8'h00);
    xfer(1'b1, 8'h0c, 8'h00);
    xfer(1'b1, 8'h20, 8'hff);
    xfer(1'b0, 8'h20, 8'h00);
    for (int k = 0; k < 8; k++)
    begin
      xfer(1'b1, 8'h00, {4'h0, k[0], 3'(k)});
      settle(2);
      chk("threshold", 8'(k), {5'h0, threshold_sel});
      chk("bandgap", {7'h0, k[0]}, {7'h0, bandgap_on});
    end
    xfer(1'b1, 8'h08, 8'h02);
    for (int m = 0; m < 4; m++)
    begin
      xfer(1'b1, 8'h04, 8'(m));
      for (int e = 0; e < 2; e++)
      begin
        pin_in <= ~pin_in;
        repeat (5) @(posedge hclk);
        xfer(1'b0, 8'h08, (m == 3 || m == e + 1) ? 8'h12 : 8'h02);
        xfer(1'b1, 8'h08, 8'h02);
      end
    end
    xfer(1'b1, 8'h0c, 8'h03);
    pulse(11'($urandom));
    settle(3);
    chk("irq", 8'h00, {7'h0, irq_req});
    for (int i = 2; i < 8; i++)
      xfer(1'b1, 8'(i * 4), 8'h00);
    xfer(1'b1, 8'h0c, 8'h03);
    cpu_en <= 1'b1;
    for (int j = 0; j < 2; j++)
    begin
      lat <= 4'(j * 7);
      xfer(1'b1, 8'h08, 8'h01);
      pulse(11'h200);
      settle(1);
      chk("irq", 8'h01, {7'h0, irq_req});
      settle(12);
      chk("irq", 8'h00, {7'h0, irq_req});
      xfer(1'b0, 8'h0c, 8'h03);
      xfer(1'b0, 8'h08, 8'h00);
    end
    cpu_en <= 1'b0;
    xfer(1'b1, 8'h18, 8'h01);
    xfer(1'b1, 8'h0c, 8'h04);
    xfer(1'b1, 8'h08, 8'h01);
    pulse(11'h008);
    settle(3);
    chk("irq", 8'h01, {7'h0, irq_req});
    xfer(1'b0, 8'h18, 8'h11);
    xfer(1'b0, 8'h0c, 8'h44);
    xfer(1'b1, 8'h08, 8'h00);
    xfer(1'b1, 8'h18, 8'h00);
    xfer(1'b1, 8'h0c, 8'h00);
    idle_mode <= 1'b1;
    pulse(11'h100);
    settle(3);
    chk("wakes", 8'h01, 8'(wakes));
    pulse(11'h100);
    settle(3);
    chk("wakes", 8'h01, 8'(wakes));
    xfer(1'b1, 8'h0c, 8'h00);
    sleep_mode <= 1'b1;
    idle_mode <= 1'b0;
    pulse(11'h100);
    settle(3);
    chk("wakes", 8'h02, 8'(wakes));
    xfer(1'b1, 8'h00, 8'h10);
    sleep_mode <= 1'b0;
    xfer(1'b1, 8'h10, 8'h01);
    for (int t = 0; t < 2; t++)
    begin
      supply_below <= 1'b1;
      repeat (100) @(posedge hclk);
      supply_below <= 1'b0;
      repeat (5) @(posedge hclk);
    end
    xfer(1'b0, 8'h10, 8'h01);
    supply_below <= 1'b1;
    settle(20);
    chk("low supply", 8'h01, {7'h0, low_supply_flag});
    chk("detector", 8'h01, {7'h0, detector_on});
    xfer(1'b0, 8'h00, 8'h30);
    idle_mode <= 1'b1;
    settle(200);
    chk("wakes", 8'h03, 8'(wakes));
    xfer(1'b0, 8'h10, 8'h11);
    idle_mode <= 1'b0;
    sleep_mode <= 1'b1;
    settle(3);
    chk("detector", 8'h00, {7'h0, detector_on});
    chk("low supply", 8'h00, {7'h0, low_supply_flag});
    xfer(1'b1, 8'h00, 8'h00);
    sleep_mode <= 1'b0;
    low_voltage_reset <= 1'b1;
    settle(3);
    chk("detector", 8'h00, {7'h0, detector_on});
    chk("bandgap", 8'h01, {7'h0, bandgap_on});
    end_of_test;
  end
endmodule
